// >>> src/psm_power_ctrl.sv
// Power-saving mode control: regulator mode, idle and sleep, doze throttling
module psm_power_ctrl #(
    parameter bit REGULATED = 1'b1,
    parameter int WAKE_DELAY_CYC = psm_pkg::WAKE_STAB_CYC
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic [psm_pkg::REG_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic SLEEP_EXEC_I,
    input wire logic INT_PENDING_I,
    input wire logic ISR_ENTRY_I,
    input wire logic ISR_RETURN_I,
    input wire logic WDT_TIMEOUT_I,
    input wire logic CLKOUT_EN_N_I,
    output logic CPU_CLK_EN_O,
    output logic PFM_EN_O,
    output logic FOSC_EN_O,
    output logic FOSC4_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic REG_LOW_POWER_O,
    output logic WDT_RESET_BLOCK_O,
    output logic CLKOUT_RUN_O,
    output psm_pkg::psm_mode_e POWER_MODE_O
);

    if (WAKE_DELAY_CYC < 1 || WAKE_DELAY_CYC >= (1 << psm_pkg::WAKE_CNT_W)) begin : g_wake_delay_check
        $error("WAKE_DELAY_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    psm_pkg::psm_vreg_s vreg_d, vreg_q;
    psm_pkg::psm_doze_s doze_d, doze_q;
    logic [7:0] rdata_d, rdata_q;
    logic wr_vreg, wr_doze;
    logic idle_int_exit;

    assign wr_vreg = REG_WR_I && (REG_ADDR_I == psm_pkg::VOLTAGE_REGULATOR_CONTROL_ADDR);
    assign wr_doze = REG_WR_I && (REG_ADDR_I == psm_pkg::DOZE_IDLE_CONTROL_ADDR);

    always_comb begin
        vreg_d = vreg_q;
        if (wr_vreg && REGULATED) begin
            vreg_d.regulator_power_mode_select = REG_WDATA_I[psm_pkg::VREG_PM_BIT];
        end
    end

    always_comb begin
        doze_d = doze_q;
        if (wr_doze) begin
            doze_d.idle_on_sleep_select = REG_WDATA_I[psm_pkg::DOZE_IDLE_BIT];
            doze_d.slow_mode_enable = REG_WDATA_I[psm_pkg::DOZE_EN_BIT];
            doze_d.recover_on_interrupt = REG_WDATA_I[psm_pkg::DOZE_ROI_BIT];
            doze_d.resume_slow_on_exit = REG_WDATA_I[psm_pkg::DOZE_DOE_BIT];
            doze_d.ratio = REG_WDATA_I[psm_pkg::DOZE_RATIO_MSB:psm_pkg::DOZE_RATIO_LSB];
        end
        doze_d.unused3 = 1'b0;
        // Hardware updates follow the software write so that they win
        if (ISR_ENTRY_I) begin
            doze_d.resume_slow_on_exit = doze_q.slow_mode_enable;
            if (doze_q.recover_on_interrupt) begin
                doze_d.slow_mode_enable = 1'b0;
            end
        end
        if (ISR_RETURN_I && doze_q.resume_slow_on_exit) begin
            doze_d.slow_mode_enable = 1'b1;
        end
        if (idle_int_exit && doze_q.recover_on_interrupt && doze_q.slow_mode_enable) begin
            doze_d.slow_mode_enable = 1'b0;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                psm_pkg::VOLTAGE_REGULATOR_CONTROL_ADDR: begin
                    // Absent on unregulated parts, so the location reads zero
                    if (REGULATED) begin
                        rdata_d[psm_pkg::VREG_PM_BIT] = vreg_q.regulator_power_mode_select;
                        rdata_d[psm_pkg::VREG_RSVD_BIT] = psm_pkg::VREG_RSVD_VALUE;
                    end
                end
                psm_pkg::DOZE_IDLE_CONTROL_ADDR: begin
                    rdata_d = doze_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            vreg_q <= psm_pkg::VREG_PM_RESET;
            doze_q <= psm_pkg::DOZE_IDLE_RESET;
            rdata_q <= 8'h00;
        end else begin
            vreg_q <= vreg_d;
            doze_q <= doze_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA_O = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Power mode sequencer

    psm_pkg::psm_mode_e mode_d, mode_q;
    logic [psm_pkg::WAKE_CNT_W-1:0] wake_cnt_d, wake_cnt_q;
    logic wake_event;
    logic lp_sleep;
    logic need_delay;

    // Unregulated parts always sleep in the lowest power state
    assign lp_sleep = REGULATED ? vreg_q.regulator_power_mode_select : 1'b1;
    assign need_delay = REGULATED && vreg_q.regulator_power_mode_select;
    // Enabled interrupt request wakes regardless of the global enable
    assign wake_event = INT_PENDING_I || WDT_TIMEOUT_I;
    assign idle_int_exit = (mode_q == psm_pkg::MODE_IDLE) && INT_PENDING_I;

    always_comb begin
        mode_d = mode_q;
        wake_cnt_d = wake_cnt_q;
        case (mode_q)
            psm_pkg::MODE_RUN: begin
                // A pending interrupt turns the sleep instruction into a no-op
                if (SLEEP_EXEC_I && !INT_PENDING_I) begin
                    if (doze_q.idle_on_sleep_select) begin
                        mode_d = psm_pkg::MODE_IDLE;
                    end else begin
                        mode_d = psm_pkg::MODE_SLEEP;
                    end
                end
            end
            psm_pkg::MODE_IDLE: begin
                if (wake_event) begin
                    mode_d = psm_pkg::MODE_RUN;
                end
            end
            psm_pkg::MODE_SLEEP: begin
                if (wake_event) begin
                    if (need_delay) begin
                        mode_d = psm_pkg::MODE_WAKE;
                        wake_cnt_d = psm_pkg::WAKE_CNT_W'(WAKE_DELAY_CYC - 1);
                    end else begin
                        mode_d = psm_pkg::MODE_RUN;
                    end
                end
            end
            psm_pkg::MODE_WAKE: begin
                if (wake_cnt_q == '0) begin
                    mode_d = psm_pkg::MODE_RUN;
                end else begin
                    wake_cnt_d = wake_cnt_q - psm_pkg::WAKE_CNT_W'(1);
                end
            end
            default: begin
                mode_d = psm_pkg::MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_q <= psm_pkg::MODE_RUN;
            wake_cnt_q <= '0;
        end else begin
            mode_q <= mode_d;
            wake_cnt_q <= wake_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock gating outputs

    logic doze_run;

    psm_doze_throttle u_throttle (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .enable_i(doze_q.slow_mode_enable),
        .ratio_i(doze_q.ratio),
        .run_o(doze_run)
    );

    assign CPU_CLK_EN_O = (mode_q == psm_pkg::MODE_RUN) && doze_run;
    assign PFM_EN_O = (mode_q == psm_pkg::MODE_RUN) && doze_run;
    assign FOSC_EN_O = (mode_q != psm_pkg::MODE_SLEEP);
    assign FOSC4_EN_O = (mode_q != psm_pkg::MODE_SLEEP);
    assign PERIPH_CLK_EN_O = (mode_q != psm_pkg::MODE_SLEEP);
    assign REG_LOW_POWER_O = (mode_q == psm_pkg::MODE_SLEEP) && lp_sleep;
    assign WDT_RESET_BLOCK_O = (mode_q == psm_pkg::MODE_IDLE) || (mode_q == psm_pkg::MODE_SLEEP);
    assign CLKOUT_RUN_O = !CLKOUT_EN_N_I && (mode_q != psm_pkg::MODE_SLEEP);
    assign POWER_MODE_O = mode_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_sleep_cmd;
        mode_q == psm_pkg::MODE_RUN && SLEEP_EXEC_I && !INT_PENDING_I;
    endsequence

    sequence s_sleep_wake;
        mode_q == psm_pkg::MODE_SLEEP && wake_event;
    endsequence

    property p_idle_entry;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_sleep_cmd and doze_q.idle_on_sleep_select |=> mode_q == psm_pkg::MODE_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

    property p_sleep_entry;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_sleep_cmd and !doze_q.idle_on_sleep_select |=> mode_q == psm_pkg::MODE_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_idle_halt;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_IDLE |-> !CPU_CLK_EN_O && !PFM_EN_O && PERIPH_CLK_EN_O && FOSC_EN_O;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("idle clock gating wrong");

    property p_idle_int_exit;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_IDLE && INT_PENDING_I && !wr_doze
            |=> mode_q == psm_pkg::MODE_RUN && $stable(doze_q.idle_on_sleep_select);
    endproperty
    a_idle_int_exit: assert property (p_idle_int_exit) else $error("idle interrupt exit wrong");

    property p_idle_roi;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        idle_int_exit && doze_q.recover_on_interrupt && doze_q.slow_mode_enable |=> !doze_q.slow_mode_enable;
    endproperty
    a_idle_roi: assert property (p_idle_roi) else $error("idle exit kept slow mode");

    property p_idle_wdt;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_IDLE && WDT_TIMEOUT_I && !INT_PENDING_I && !wr_doze && !ISR_ENTRY_I
            && !ISR_RETURN_I |-> WDT_RESET_BLOCK_O ##1 (mode_q == psm_pkg::MODE_RUN
            && $stable(doze_q.slow_mode_enable));
    endproperty
    a_idle_wdt: assert property (p_idle_wdt) else $error("watchdog idle wake wrong");

    property p_sleep_clk;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_sleep_cmd and !doze_q.idle_on_sleep_select |=> !FOSC_EN_O && !FOSC4_EN_O && !CPU_CLK_EN_O;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("system clock alive in sleep");

    property p_clkout_idle;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_IDLE && !CLKOUT_EN_N_I |-> CLKOUT_RUN_O;
    endproperty
    a_clkout_idle: assert property (p_clkout_idle) else $error("clock output stopped in idle");

    property p_roi_entry;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        ISR_ENTRY_I && doze_q.recover_on_interrupt && !ISR_RETURN_I |=> !doze_q.slow_mode_enable;
    endproperty
    a_roi_entry: assert property (p_roi_entry) else $error("service entry kept slow mode");

    property p_doe_exit;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        ISR_RETURN_I && doze_q.resume_slow_on_exit && !idle_int_exit |=> doze_q.slow_mode_enable;
    endproperty
    a_doe_exit: assert property (p_doe_exit) else $error("service return did not set slow mode");

    property p_wake_slow;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_sleep_wake and need_delay |=> (mode_q == psm_pkg::MODE_WAKE && !CPU_CLK_EN_O)
            ##[0:1000] mode_q == psm_pkg::MODE_RUN;
    endproperty
    a_wake_slow: assert property (p_wake_slow) else $error("low-power wake delay wrong");

    property p_wake_fast;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_sleep_wake and !need_delay |=> mode_q == psm_pkg::MODE_RUN;
    endproperty
    a_wake_fast: assert property (p_wake_fast) else $error("normal wake delayed");

    property p_vreg_read;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        REG_RD_I && REG_ADDR_I == psm_pkg::VOLTAGE_REGULATOR_CONTROL_ADDR |=>
            REG_RDATA_O[7:2] == 6'h00 && REG_RDATA_O[0] == REGULATED;
    endproperty
    a_vreg_read: assert property (p_vreg_read) else $error("regulator register read wrong");

    property p_lp_sleep;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        s_sleep_cmd and !doze_q.idle_on_sleep_select and lp_sleep |=> REG_LOW_POWER_O;
    endproperty
    a_lp_sleep: assert property (p_lp_sleep) else $error("regulator not in low power in sleep");

    property p_reg_normal;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q != psm_pkg::MODE_SLEEP || (REGULATED && !vreg_q.regulator_power_mode_select) |-> !REG_LOW_POWER_O;
    endproperty
    a_reg_normal: assert property (p_reg_normal) else $error("regulator left normal configuration");

    property p_sleep_refused;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_RUN && SLEEP_EXEC_I && INT_PENDING_I |=> mode_q == psm_pkg::MODE_RUN;
    endproperty
    a_sleep_refused: assert property (p_sleep_refused) else $error("sleep taken with interrupt pending");

    property p_wake_hold;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_WAKE && wake_cnt_q != '0 |=> mode_q == psm_pkg::MODE_WAKE && !CPU_CLK_EN_O;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake delay cut short");

    property p_wake_end;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_WAKE && wake_cnt_q == '0 |=> mode_q == psm_pkg::MODE_RUN;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("wake delay overran");

    property p_clk_sleep;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        mode_q == psm_pkg::MODE_SLEEP |-> !FOSC_EN_O && !FOSC4_EN_O && !CLKOUT_RUN_O;
    endproperty
    a_clk_sleep: assert property (p_clk_sleep) else $error("system clock running in sleep");

    property p_roi_keep;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        ISR_ENTRY_I && !doze_q.recover_on_interrupt && !ISR_RETURN_I && !idle_int_exit && !wr_doze
            |=> $stable(doze_q.slow_mode_enable);
    endproperty
    a_roi_keep: assert property (p_roi_keep) else $error("service entry changed slow mode");

    property p_doe_keep;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        ISR_RETURN_I && !doze_q.resume_slow_on_exit && !ISR_ENTRY_I && !idle_int_exit && !wr_doze
            |=> $stable(doze_q.slow_mode_enable);
    endproperty
    a_doe_keep: assert property (p_doe_keep) else $error("service return changed slow mode");

endmodule : psm_power_ctrl

// >>> src/psm_pkg.sv
// Constants, types and helper functions of the power-saving mode control block
package psm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int REG_ADDR_W = 4;
    localparam logic [3:0] VOLTAGE_REGULATOR_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] DOZE_IDLE_CONTROL_ADDR = 4'h1;

    // Regulator control field positions and reset values
    localparam int VREG_RSVD_BIT = 0;
    localparam int VREG_PM_BIT = 1;
    localparam logic VREG_PM_RESET = 1'b0;
    localparam logic VREG_RSVD_VALUE = 1'b1;

    // Doze and idle control field positions and reset value
    localparam int DOZE_RATIO_LSB = 0;
    localparam int DOZE_RATIO_MSB = 2;
    localparam int DOZE_DOE_BIT = 4;
    localparam int DOZE_ROI_BIT = 5;
    localparam int DOZE_EN_BIT = 6;
    localparam int DOZE_IDLE_BIT = 7;
    localparam logic [7:0] DOZE_IDLE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int WAKE_STAB_TIME_NS = 5000;
    localparam int WAKE_STAB_CYC = (WAKE_STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 16;
    localparam int DOZE_CNT_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_SLEEP,
        MODE_WAKE
    } psm_mode_e;

    typedef struct packed {
        logic idle_on_sleep_select;
        logic slow_mode_enable;
        logic recover_on_interrupt;
        logic resume_slow_on_exit;
        logic unused3;
        logic [2:0] ratio;
    } psm_doze_s;

    typedef struct packed {
        logic regulator_power_mode_select;
    } psm_vreg_s;

    // Last count of one ratio period: period is 2 to the power of code plus one
    function automatic logic [DOZE_CNT_W-1:0] doze_last(input logic [2:0] ratio);
        logic [DOZE_CNT_W:0] period;
        period = 9'h002 << ratio;
        return DOZE_CNT_W'(period - 9'h001);
    endfunction : doze_last

endpackage : psm_pkg

// >>> src/psm_doze_throttle.sv
// Doze ratio counter that marks the CPU cycles allowed to run
module psm_doze_throttle (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic [2:0] ratio_i,
    output logic run_o
);

    logic [psm_pkg::DOZE_CNT_W-1:0] cnt_d, cnt_q;
    logic en_d, en_q;
    logic [2:0] ratio_d, ratio_q;
    logic restart;
    logic [psm_pkg::DOZE_CNT_W-1:0] last;

    always_comb begin
        last = psm_pkg::doze_last(ratio_i);
        restart = (enable_i != en_q) || (ratio_i != ratio_q);
        en_d = enable_i;
        ratio_d = ratio_i;
        if (!enable_i) begin
            cnt_d = '0;
        end else if (restart) begin
            cnt_d = psm_pkg::DOZE_CNT_W'(1);
        end else if (cnt_q == last) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + psm_pkg::DOZE_CNT_W'(1);
        end
        // Restart cycle is the first active cycle of the new period
        run_o = !enable_i || restart || (cnt_q == '0);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            en_q <= 1'b0;
            ratio_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
            en_q <= en_d;
            ratio_q <= ratio_d;
        end
    end

    property p_doze_stall;
        @(posedge clk_i) disable iff (!rst_n_i)
        (enable_i && !restart && cnt_q == '0) ##1 (enable_i && !restart) |-> !run_o;
    endproperty
    a_doze_stall: assert property (p_doze_stall) else $error("doze did not stall after run cycle");

    property p_doze_period;
        @(posedge clk_i) disable iff (!rst_n_i)
        (enable_i && !restart && cnt_q == last) ##1 (enable_i && !restart) |-> run_o;
    endproperty
    a_doze_period: assert property (p_doze_period) else $error("doze period end missed run cycle");

    property p_doze_restart;
        @(posedge clk_i) disable iff (!rst_n_i)
        (enable_i && restart) ##1 (enable_i && !restart) |-> !run_o;
    endproperty
    a_doze_restart: assert property (p_doze_restart) else $error("doze restart phase wrong");

endmodule : psm_doze_throttle

// >>> tb/psm_power_ctrl_test.sv
// Self-checking testbench of the power-saving mode control block
module psm_power_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int WAKE_CYC = 3;
    localparam int MAX_CYC = 20000;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic slp = 1'b0;
    logic int_pend = 1'b0;
    logic isr_in = 1'b0;
    logic isr_out = 1'b0;
    logic wdt = 1'b0;
    logic clkout_n = 1'b0;
    logic [7:0] rdata;
    logic cpu_en, pfm_en, fosc_en, fosc4_en, periph_en, low_pwr, wdt_blk, clkout_run;
    psm_pkg::psm_mode_e mode;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    psm_power_ctrl #(.REGULATED(1'b1), .WAKE_DELAY_CYC(WAKE_CYC)) psm_power_ctrl_i (
        .MCLK_I(mclk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .SLEEP_EXEC_I(slp), .INT_PENDING_I(int_pend),
        .ISR_ENTRY_I(isr_in), .ISR_RETURN_I(isr_out), .WDT_TIMEOUT_I(wdt), .CLKOUT_EN_N_I(clkout_n),
        .CPU_CLK_EN_O(cpu_en), .PFM_EN_O(pfm_en), .FOSC_EN_O(fosc_en), .FOSC4_EN_O(fosc4_en),
        .PERIPH_CLK_EN_O(periph_en), .REG_LOW_POWER_O(low_pwr), .WDT_RESET_BLOCK_O(wdt_blk),
        .CLKOUT_RUN_O(clkout_run), .POWER_MODE_O(mode)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #12.5 mclk = ~mclk;

    // Cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == MAX_CYC) begin
            num_errors++;
            $display("Error at %0t: run took too long", $time);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, "register read");
    endtask : reg_chk

    // One-cycle event: 0 sleep, 1 interrupt, 2 service entry, 3 service return, 4 watchdog
    task automatic pulse(input int which);
        @(posedge mclk);
        case (which)
            0: slp <= 1'b1;
            1: int_pend <= 1'b1;
            2: isr_in <= 1'b1;
            3: isr_out <= 1'b1;
            default: wdt <= 1'b1;
        endcase
        @(posedge mclk);
        {slp, int_pend, isr_in, isr_out, wdt} <= 5'h00;
        #1;
    endtask : pulse

    task automatic chk_mode(input psm_pkg::psm_mode_e m);
        chk({6'h00, mode}, {6'h00, m}, "power mode");
    endtask : chk_mode

    // Enables in order cpu, flash, fosc, fosc4, periph, low power, reset block, clock out
    task automatic outs(input logic [7:0] exp, input psm_pkg::psm_mode_e m);
        chk({cpu_en, pfm_en, fosc_en, fosc4_en, periph_en, low_pwr, wdt_blk, clkout_run}, exp, "enables");
        chk_mode(m);
    endtask : outs

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        outs(8'hF9, psm_pkg::MODE_RUN);
        reg_chk(4'h0, 8'h01);
        reg_chk(4'h1, 8'h00);
        reg_chk(4'h2, 8'h00);
    endtask : t_reset

    task automatic t_regulator();
        reg_wr(4'h0, 8'hFF);
        reg_chk(4'h0, 8'h03);
        reg_wr(4'h0, 8'h01);
        reg_chk(4'h0, 8'h01);
    endtask : t_regulator

    task automatic t_sleep(input logic lp);
        reg_wr(4'h0, {6'h00, lp, 1'b1});
        reg_wr(4'h1, 8'h00);
        pulse(0);
        outs(lp ? 8'h06 : 8'h02, psm_pkg::MODE_SLEEP);
        // An interrupt or a watchdog timeout wakes from sleep; here an interrupt does
        pulse(1);
        if (lp) begin
            for (int i = 0; i < WAKE_CYC; i++) begin
                outs(8'h39, psm_pkg::MODE_WAKE);
                @(posedge mclk);
                #1;
            end
        end
        outs(8'hF9, psm_pkg::MODE_RUN);
    endtask : t_sleep

    task automatic t_idle();
        reg_wr(4'h1, 8'hE0);
        pulse(0);
        outs(8'h3B, psm_pkg::MODE_IDLE);
        pulse(4);
        chk_mode(psm_pkg::MODE_RUN);
        reg_chk(4'h1, 8'hE0);
        pulse(0);
        chk_mode(psm_pkg::MODE_IDLE);
        pulse(1);
        outs(8'hF9, psm_pkg::MODE_RUN);
        reg_chk(4'h1, 8'hA0);
        pulse(0);
        chk_mode(psm_pkg::MODE_IDLE);
        pulse(1);
        chk_mode(psm_pkg::MODE_RUN);
    endtask : t_idle

    task automatic t_isr();
        reg_wr(4'h1, 8'h60);
        pulse(2);
        reg_chk(4'h1, 8'h30);
        pulse(3);
        reg_chk(4'h1, 8'h70);
        reg_wr(4'h1, 8'h40);
        pulse(2);
        reg_chk(4'h1, 8'h50);
        reg_wr(4'h1, 8'h00);
        pulse(3);
        reg_chk(4'h1, 8'h00);
    endtask : t_isr

    // The first write turns slow mode on and each later ratio is written while it stays on, so the phase must restart
    task automatic t_doze();
        logic e;
        for (int r = 0; r < 8; r++) begin
            reg_wr(4'h1, {5'h08, 3'(r)});
            for (int i = 0; i < (4 << r); i++) begin
                e = (i % (2 << r)) == 0;
                chk({6'h00, cpu_en, pfm_en}, {6'h00, e, e}, "slow mode slot");
                @(posedge mclk);
                #1;
            end
        end
        reg_wr(4'h1, 8'h00);
        repeat (4) begin
            chk({7'h00, cpu_en}, 8'h01, "full speed");
            @(posedge mclk);
            #1;
        end
    endtask : t_doze

    // Clock-out strap, refused sleep, watchdog wake from sleep, entry and return together
    task automatic t_misc();
        reg_wr(4'h0, 8'h01);
        reg_wr(4'h1, 8'h80);
        clkout_n <= 1'b1;
        pulse(0);
        outs(8'h3A, psm_pkg::MODE_IDLE);
        pulse(4);
        clkout_n <= 1'b0;
        chk_mode(psm_pkg::MODE_RUN);
        @(posedge mclk);
        {slp, int_pend} <= 2'b11;
        @(posedge mclk);
        {slp, int_pend} <= 2'b00;
        #1;
        chk_mode(psm_pkg::MODE_RUN);
        reg_wr(4'h1, 8'h00);
        pulse(0);
        chk_mode(psm_pkg::MODE_SLEEP);
        pulse(4);
        chk_mode(psm_pkg::MODE_RUN);
        reg_wr(4'h1, 8'h70);
        @(posedge mclk);
        {isr_in, isr_out} <= 2'b11;
        @(posedge mclk);
        {isr_in, isr_out} <= 2'b00;
        #1;
        reg_chk(4'h1, 8'h70);
        @(posedge mclk);
        #1;
        chk(rdata, 8'h00, "read data after its cycle");
    endtask : t_misc

    // Reset in mid-run returns every register and output to its reset state
    task automatic t_reset_mid();
        reg_wr(4'h0, 8'h03);
        reg_wr(4'h1, 8'hFD);
        reg_chk(4'h1, 8'hF5);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
    endtask : t_reset_mid

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_regulator();
        t_sleep(1'b1);
        t_sleep(1'b0);
        t_idle();
        t_isr();
        t_doze();
        t_misc();
        t_reset_mid();
        conclude();
    end

endmodule : psm_power_ctrl_test
